/* File: design/nco_feed.sv */
// controlling end: register port in, oscillator link out
`timescale 1ns/10ps
`default_nettype none
module nco_feed #(
  parameter int A = nco_pkg::ACC_W,
  parameter int F = nco_pkg::FM_W,
  parameter int P = nco_pkg::PM_W,
  parameter int M = nco_pkg::MAG_W,
  parameter int CH = nco_pkg::CHANNELS,
  parameter int DEPTH = nco_pkg::HOP_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // link
  nco_link_if.feed lnk
);
  localparam int HAW = $clog2(DEPTH);
  localparam int CHW = (CH > 1) ? $clog2(CH) : 1;

  logic [31:0] ctrl_q;
  logic [F-1:0] fm_q;
  logic [P-1:0] pm_q;
  logic [HAW-1:0] fsel_q;
  logic [HAW-1:0] hop_addr_q;
  logic hop_wr_q;
  logic [A-1:0] inc_q [CH];
  logic [CHW-1:0] slot_q;
  logic [M-1:0] sin_q;
  logic [M-1:0] cos_q;
  logic [15:0] cnt_q;
  logic [CHW-1:0] lch_q;
  logic [31:0] rdata_q;
  logic load_sel;

  assign load_sel = wr && (addr == nco_pkg::REG_HOP);

  // ==========================================================
  // software-written settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= nco_pkg::CTRL_RESET;
      fm_q <= '0;
      pm_q <= '0;
      fsel_q <= '0;
      for (int i = 0; i < CH; i++) begin
        inc_q[i] <= '0;
      end
    end else if (wr) begin
      case (addr)
        nco_pkg::REG_CTRL: ctrl_q <= wdata;
        nco_pkg::REG_FM: fm_q <= F'(wdata);
        nco_pkg::REG_PM: pm_q <= P'(wdata);
        nco_pkg::REG_FSEL: fsel_q <= HAW'(wdata);
        default: begin
          for (int i = 0; i < CH; i++) begin
            if (addr == nco_pkg::REG_INC0 + 8'(4 * i)) begin
              inc_q[i] <= A'(wdata);
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // bank load: one-cycle strobe, increment taken from channel zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hop_wr_q <= 1'b0;
      hop_addr_q <= '0;
    end else begin
      hop_wr_q <= load_sel;
      if (load_sel) begin
        hop_addr_q <= HAW'(wdata);
      end
    end
  end

  // ==========================================================
  // increment slot: channel zero first after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= '0;
    end else if (lnk.clken) begin
      slot_q <= (slot_q == CHW'(CH - 1)) ? '0 : slot_q + 1'b1;
    end
  end

  // ==========================================================
  // capture of the last valid sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sin_q <= '0;
      cos_q <= '0;
      cnt_q <= '0;
      lch_q <= '0;
    end else if (lnk.out_valid && lnk.clken) begin
      sin_q <= lnk.sin_out;
      cos_q <= lnk.cos_out;
      lch_q <= lnk.out_chan;
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (rd) begin
      case (addr)
        nco_pkg::REG_CTRL: rdata_q <= ctrl_q;
        nco_pkg::REG_FM: rdata_q <= 32'(fm_q);
        nco_pkg::REG_PM: rdata_q <= 32'(pm_q);
        nco_pkg::REG_FSEL: rdata_q <= 32'(fsel_q);
        nco_pkg::REG_SIN: rdata_q <= 32'(signed'(sin_q));
        nco_pkg::REG_COS: rdata_q <= 32'(signed'(cos_q));
        nco_pkg::REG_STAT: rdata_q <= (32'(lch_q) << nco_pkg::STAT_CH_LSB) | 32'(cnt_q);
        default: begin
          rdata_q <= '0;
          for (int i = 0; i < CH; i++) begin
            if (addr == nco_pkg::REG_INC0 + 8'(4 * i)) begin
              rdata_q <= 32'(inc_q[i]);
            end
          end
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata = rdata_q;
  assign lnk.clken = ctrl_q[nco_pkg::CTRL_EN_BIT];
  assign lnk.phi_inc = hop_wr_q ? inc_q[0] : inc_q[slot_q];
  assign lnk.freq_mod = fm_q;
  assign lnk.phase_mod = pm_q;
  assign lnk.hop_addr = hop_addr_q;
  assign lnk.hop_wr = hop_wr_q;
  assign lnk.freq_sel = fsel_q;
endmodule
`default_nettype wire

/* File: design/nco_link_if.sv */
// link between the oscillator and the logic that feeds it
`timescale 1ns/10ps
`default_nettype none
interface nco_link_if #(
  parameter int A = 32,
  parameter int F = 32,
  parameter int P = 32,
  parameter int M = 18,
  parameter int HOP_AW = 4,
  parameter int CH_W = 2
);
  logic clken;
  logic [A-1:0] phi_inc;
  logic [F-1:0] freq_mod;
  logic [P-1:0] phase_mod;
  logic [HOP_AW-1:0] hop_addr;
  logic hop_wr;
  logic [HOP_AW-1:0] freq_sel;
  logic [M-1:0] sin_out;
  logic [M-1:0] cos_out;
  logic out_valid;
  logic [CH_W-1:0] out_chan;

  modport osc (
    input clken, phi_inc, freq_mod, phase_mod, hop_addr, hop_wr, freq_sel,
    output sin_out, cos_out, out_valid, out_chan
  );
  modport feed (
    output clken, phi_inc, freq_mod, phase_mod, hop_addr, hop_wr, freq_sel,
    input sin_out, cos_out, out_valid, out_chan
  );
endinterface
`default_nettype wire

/* File: design/nco_osc.sv */
// numerically controlled oscillator end of the link
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module nco_osc #(
  parameter int A = nco_pkg::ACC_W,
  parameter int ANG = nco_pkg::ANG_W,
  parameter int M = nco_pkg::MAG_W,
  parameter int F = nco_pkg::FM_W,
  parameter int P = nco_pkg::PM_W,
  parameter int CH = nco_pkg::CHANNELS,
  parameter int DEPTH = nco_pkg::HOP_DEPTH,
  parameter int DITHER = nco_pkg::DITHER_LVL,
  parameter bit HOP_EN = 1'b1,
  parameter bit FM_EN = 1'b1,
  parameter bit PM_EN = 1'b1,
  parameter bit DUAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  nco_link_if.osc lnk
);
  localparam int HAW = $clog2(DEPTH);
  localparam int CHW = (CH > 1) ? $clog2(CH) : 1;
  localparam int LAT = nco_pkg::BASE_LAT + ((DITHER > 0) ? nco_pkg::DITHER_LAT : 0);
  localparam int LCW = $clog2(LAT + 1);
  localparam int XW = ANG - 1;

  logic [A-1:0] bank_q [DEPTH];
  logic [A-1:0] inc_q;
  logic [F-1:0] fm_q;
  logic [P-1:0] pm_q;
  logic [CHW-1:0] ch_q;
  logic [CHW-1:0] ch1_q;
  logic [A-1:0] acc_q [CH];
  logic [A-1:0] ph_q;
  logic [CHW-1:0] ch2_q;
  logic [ANG-1:0] ang;
  logic [CHW-1:0] ang_ch;
  logic [M-1:0] sin_q;
  logic [M-1:0] cos_q;
  logic [CHW-1:0] och_q;
  logic [LCW-1:0] fill_q;
  logic valid_q;

  // ==========================================================
  // sine from a parabolic half-wave shape, sign from the top bit
  function automatic logic [M-1:0] shape(input logic [ANG-1:0] t);
    logic [XW-1:0] x;
    logic [XW-1:0] xn;
    logic [2*XW-1:0] y;
    logic [M-1:0] mag;
    x = t[XW-1:0];
    // complement kept at XW bits so the product stays x * (1 - x)
    xn = ~x;
    y = x * xn;
    mag = {1'b0, y[2*XW-3 -: M-1]};
    shape = t[ANG-1] ? (~mag + 1'b1) : mag;
  endfunction

  // ==========================================================
  // hopping bank, written regardless of clock enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        bank_q[i] <= '0;
      end
    end else if (HOP_EN && lnk.hop_wr) begin
      bank_q[lnk.hop_addr] <= lnk.phi_inc;
    end
  end

  // ==========================================================
  // input stage: increment, modulation words, channel slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inc_q <= '0;
      fm_q <= '0;
      pm_q <= '0;
      ch_q <= '0;
      ch1_q <= '0;
    end else if (lnk.clken) begin
      inc_q <= HOP_EN ? bank_q[lnk.freq_sel] : lnk.phi_inc;
      fm_q <= FM_EN ? lnk.freq_mod : '0;
      pm_q <= PM_EN ? lnk.phase_mod : '0;
      ch1_q <= ch_q;
      // slot counter starts at channel zero after reset
      ch_q <= (ch_q == CHW'(CH - 1)) ? '0 : ch_q + 1'b1;
    end
  end

  // ==========================================================
  // per-channel accumulators and phase offset stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CH; i++) begin
        acc_q[i] <= '0;
      end
      ph_q <= '0;
      ch2_q <= '0;
    end else if (lnk.clken) begin
      acc_q[ch1_q] <= acc_q[ch1_q] + inc_q + A'(fm_q);
      ph_q <= acc_q[ch1_q] + (A'(pm_q) << (A - P));
      ch2_q <= ch1_q;
    end
  end

  // ==========================================================
  // optional dither: two extra stages
  generate
    if (DITHER > 0) begin : g_dither
      logic [15:0] lfsr_q;
      logic [A-1:0] d1_q;
      logic [ANG-1:0] d2_q;
      logic [CHW-1:0] dc1_q;
      logic [CHW-1:0] dc2_q;
      // pseudo-random noise below the kept angular bits
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lfsr_q <= 16'h0001;
          d1_q <= '0;
          d2_q <= '0;
          dc1_q <= '0;
          dc2_q <= '0;
        end else if (lnk.clken) begin
          lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
          d1_q <= ph_q + (A'(lfsr_q[DITHER-1:0]) << (A - ANG - DITHER));
          d2_q <= d1_q[A-1 -: ANG];
          dc1_q <= ch2_q;
          dc2_q <= dc1_q;
        end
      end
      assign ang = d2_q;
      assign ang_ch = dc2_q;
    end else begin : g_plain
      assign ang = ph_q[A-1 -: ANG];
      assign ang_ch = ch2_q;
    end
  endgenerate

  // ==========================================================
  // lookup stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sin_q <= '0;
      cos_q <= '0;
      och_q <= '0;
    end else if (lnk.clken) begin
      sin_q <= shape(ang);
      cos_q <= DUAL ? shape(ang + ANG'(1 << (ANG - 2))) : '0;
      och_q <= ang_ch;
    end
  end

  // ==========================================================
  // valid once the pipeline holds a real sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_q <= '0;
      valid_q <= 1'b0;
    end else if (lnk.clken) begin
      if (fill_q != LCW'(LAT)) begin
        fill_q <= fill_q + 1'b1;
      end
      valid_q <= (fill_q >= LCW'(LAT - 1));
    end
  end

  assign lnk.sin_out = sin_q;
  assign lnk.cos_out = cos_q;
  assign lnk.out_valid = valid_q;
  assign lnk.out_chan = och_q;
endmodule
`default_nettype wire

/* File: design/nco_pkg.sv */
// shared constants of the oscillator and its controlling end
package nco_pkg;
  // ==========================================================
  // reference configuration
  localparam int ACC_W = 32;      // accumulator precision
  localparam int ANG_W = 17;      // angular bits kept for lookup
  localparam int MAG_W = 18;      // magnitude precision
  localparam int FM_W = 32;       // frequency modulation width
  localparam int PM_W = 32;       // phase modulation precision
  localparam int CHANNELS = 4;    // time-shared channels
  localparam int HOP_DEPTH = 16;  // hopping increment registers
  localparam int DITHER_LVL = 3;  // dither level
  // ==========================================================
  // latency figures in clock-enabled cycles
  localparam int BASE_LAT = 3;    // input, phase, lookup stages
  localparam int DITHER_LAT = 2;  // extra stages with dither on
  // ==========================================================
  // controller register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;   // bit0 enable
  localparam logic [7:0] REG_FM = 8'h08;     // modulation word
  localparam logic [7:0] REG_PM = 8'h0c;     // phase offset word
  localparam logic [7:0] REG_HOP = 8'h10;    // write: bank load
  localparam logic [7:0] REG_FSEL = 8'h14;   // bank select
  localparam logic [7:0] REG_SIN = 8'h18;    // last sine
  localparam logic [7:0] REG_COS = 8'h1c;    // last cosine
  localparam logic [7:0] REG_STAT = 8'h20;   // count, channel
  localparam logic [7:0] REG_INC0 = 8'h40;   // channel increments
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_CH_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage

/* File: verification/nco_checker.sv */
// link assertions for the oscillator and its feeding end
`timescale 1ns/10ps
`default_nettype none
module nco_checker #(
  parameter int M = 18,
  parameter int LAT = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link signals
  input wire logic clken,
  input wire logic hop_wr,
  input wire logic [M-1:0] sin_out,
  input wire logic [M-1:0] cos_out,
  input wire logic out_valid,
  input wire logic [1:0] out_chan
);
  // ====
  // enabled edges since reset, saturating
  logic [3:0] en_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 4'h0;
    end else if (clken && en_q != 4'hf) begin
      en_q <= en_q + 4'h1;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_stay; out_valid |=> out_valid; endproperty
  a_stay: assert property (p_stay) else $error("valid dropped");
  property p_lat; $rose(out_valid) |-> en_q == 4'(LAT); endproperty
  a_lat: assert property (p_lat) else $error("valid latency wrong");
  property p_first; $rose(out_valid) |-> out_chan == 2'h0; endproperty
  a_first: assert property (p_first) else $error("first sample not channel 0");
  property p_step; clken && out_valid |=> out_chan == $past(out_chan) + 2'h1; endproperty
  a_step: assert property (p_step) else $error("channel order broken");
  property p_hold;
    !clken |=> $stable(sin_out) && $stable(cos_out) && $stable(out_chan);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved while disabled");
  property p_rise; $rose(out_valid) |-> $past(clken); endproperty
  a_rise: assert property (p_rise) else $error("valid rose on idle edge");
  property p_pulse; hop_wr |=> !hop_wr; endproperty
  a_pulse: assert property (p_pulse) else $error("bank strobe too long");
  property p_rst;
    disable iff (1'b0) !rst_n |-> !out_valid && !clken && !hop_wr && sin_out == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset did not clear link");
  // main scenarios seen
  c_valid: cover property ($rose(out_valid));
  c_hop: cover property (hop_wr);
  c_stall: cover property (out_valid && !clken);
endmodule
`default_nettype wire

/* File: verification/numeric_oscillator_top_test.sv */
// bench joining the feeding end and the oscillator
`timescale 1ns/10ps
`default_nettype none
module numeric_oscillator_top_test;
  // ====
  // signals and instances
  localparam int LAT = nco_pkg::BASE_LAT + nco_pkg::DITHER_LAT;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [nco_pkg::MAG_W-1:0] smp;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  nco_link_if lnk ();
  nco_osc u_nco_osc (.clk(clk), .rst_n(rst_n), .lnk(lnk.osc));
  nco_feed u_nco_feed (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .lnk(lnk.feed));
  nco_checker #(.M(nco_pkg::MAG_W), .LAT(LAT)) u_nco_checker (.clk(clk), .rst_n(rst_n),
    .clken(lnk.clken), .hop_wr(lnk.hop_wr), .sin_out(lnk.sin_out),
    .cos_out(lnk.cos_out), .out_valid(lnk.out_valid), .out_chan(lnk.out_chan));
  // 100 ns clock
  initial begin
    forever #50 clk = ~clk;
  end
  // ====
  // shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input string what, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(what, rdata, exp);
  endtask
  // channel 0 sine must differ one visit later
  task automatic moves(input string what);
    repeat (LAT + 2) @(negedge clk);
    n = 0;
    while (lnk.out_chan !== 2'h0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    check("chan0", lnk.out_chan, 2'h0);
    smp = lnk.sin_out;
    repeat (4) @(negedge clk);
    check(what, lnk.sin_out != smp, 1'b1);
  endtask
  // ====
  // scenarios
  task automatic t_regs();
    rd_reg(nco_pkg::REG_CTRL, "ctrl", nco_pkg::CTRL_RESET);
    wr_reg(8'h04, 32'hffff_ffff);
    rd_reg(8'h04, "unmapped", 32'h0);
    check("idle valid", lnk.out_valid, 1'b0);
  endtask
  // bank load strobe carries index and word
  task automatic t_hop();
    wr_reg(nco_pkg::REG_INC0, 32'h1000_0000);
    rd_reg(nco_pkg::REG_INC0, "inc0", 32'h1000_0000);
    wr_reg(nco_pkg::REG_HOP, 32'h5);
    @(negedge clk);
    check("hop_wr", lnk.hop_wr, 1'b1);
    check("hop_addr", lnk.hop_addr, 4'h5);
    check("phi_inc", lnk.phi_inc, 32'h1000_0000);
  endtask
  // enable, count edges to first sample, follow channels
  task automatic t_start();
    wr_reg(nco_pkg::REG_CTRL, 32'h1);
    n = 0;
    while (lnk.out_valid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 40) begin
        bad_count++;
        final_report();
      end
    end
    check("latency", n, LAT + 1);
    for (int k = 0; k < 8; k++) begin
      check("chan", lnk.out_chan, k % 4);
      @(negedge clk);
    end
  endtask
  // sign and size of a sample at a fixed phase offset
  task automatic t_phase(input logic [31:0] pm, input bit cosine, input logic neg);
    wr_reg(nco_pkg::REG_PM, pm);
    repeat (LAT + 4) @(negedge clk);
    smp = cosine ? lnk.cos_out : lnk.sin_out;
    check("sign", smp[nco_pkg::MAG_W-1], neg);
    check("zero", smp == '0, 1'b0);
    // every channel sits at one phase, so the captured sample matches the link
    rd_reg(cosine ? nco_pkg::REG_COS : nco_pkg::REG_SIN, "sample reg", 32'(signed'(smp)));
  endtask
  // selected bank entry, then modulation, advance the phase
  task automatic t_sel();
    wr_reg(nco_pkg::REG_FSEL, 32'h5);
    rd_reg(nco_pkg::REG_FSEL, "fsel", 32'h5);
    check("freq_sel", lnk.freq_sel, 4'h5);
    moves("hop step");
    wr_reg(nco_pkg::REG_FSEL, 32'h0);
    wr_reg(nco_pkg::REG_FM, 32'h1000_0000);
    rd_reg(nco_pkg::REG_FM, "fm", 32'h1000_0000);
    moves("fm step");
  endtask
  // enable low freezes the outputs
  task automatic t_hold();
    wr_reg(nco_pkg::REG_CTRL, 32'h0);
    @(negedge clk);
    smp = lnk.sin_out;
    n = lnk.out_chan;
    repeat (6) @(negedge clk);
    check("held sin", lnk.sin_out, smp);
    check("held chan", lnk.out_chan, n);
    check("held valid", lnk.out_valid, 1'b1);
  endtask
  // reset in mid-run clears link and control
  task automatic t_reset();
    wr_reg(nco_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check("rst valid", lnk.out_valid, 1'b0);
    check("rst sin", lnk.sin_out, '0);
    check("rst clken", lnk.clken, 1'b0);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(nco_pkg::REG_CTRL, "ctrl", nco_pkg::CTRL_RESET);
  endtask
  // main sequence
  initial begin
    // falling edge at time zero so the asynchronous clears run at once
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_hop();
    t_start();
    t_phase(32'h4000_0000, 1'b0, 1'b0);
    t_phase(32'hc000_0000, 1'b0, 1'b1);
    t_phase(32'h0000_0000, 1'b1, 1'b0);
    t_phase(32'h8000_0000, 1'b1, 1'b1);
    t_sel();
    t_hold();
    t_reset();
    t_start();
    final_report();
  end
endmodule
`default_nettype wire
